// ===== rtl/twg_defines.svh
`ifndef TWG_DEFINES_SVH
`define TWG_DEFINES_SVH

// ------------------------------------------------------------
// Special-function addresses
// ------------------------------------------------------------
`define TWG_ADDR_KEY         8'hC7
`define TWG_ADDR_PWR_MON     8'hA3
`define TWG_ADDR_CHIP_CTL    8'h9F
`define TWG_ADDR_PROG_TRIG   8'hA4
`define TWG_ADDR_WDOG_CTL0   8'hD8
`define TWG_ADDR_WDOG_CTL1   8'hAB

// ------------------------------------------------------------
// Key values and reset values
// ------------------------------------------------------------
`define TWG_KEY_FIRST        8'hAA
`define TWG_KEY_SECOND       8'h55
`define TWG_KEY_RESET        8'hFF
`define TWG_PROT_RESET       8'h00
`define TWG_READ_NONE        8'h00

// ------------------------------------------------------------
// Timing in machine cycles, clocks per machine cycle, protected register count
// ------------------------------------------------------------
`define TWG_KEY_WAIT_MC      3
`define TWG_WINDOW_MC        3
`define TWG_CLKS_PER_MC      4
`define TWG_NUM_PROT         5

`endif

// ===== rtl/twg_pkg.sv
package twg_pkg;

  // ------------------------------------------------------------
  // Bus request, protected register bank and guard state
  // ------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } twg_sfr_req_t;

  typedef logic [4:0][7:0] twg_prot_bank_t;

  typedef enum logic [1:0] {
    TWG_IDLE  = 2'b00,
    TWG_ARMED = 2'b01,
    TWG_OPEN  = 2'b10
  } twg_state_t;

endpackage : twg_pkg

// ===== rtl/twg_mc_count.sv
`include "twg_defines.svh"

module twg_mc_count #(
  parameter int          WIDTH = 3,
  parameter logic [2:0]  LOAD  = 3'd3
) (
  input  wire logic clk,      // System clock
  input  wire logic rst_b,    // Synchronous reset, active low
  input  wire logic load,     // Restart the interval
  input  wire logic clear,    // Abandon the interval
  input  wire logic mc_tick,  // One pulse per machine cycle
  output logic      active_q  // Interval running
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  if (WIDTH != 3) begin : g_bad_width
    $error("twg_mc_count: WIDTH must be 3");
  end

  always_comb begin
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = '0;
    end else if (load) begin
      cnt_d = LOAD;
    end else if (mc_tick && (cnt_q != '0)) begin
      cnt_d = cnt_q - 3'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q    <= '0;
      active_q <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      active_q <= (cnt_d != '0);
    end
  end

endmodule : twg_mc_count

// ===== rtl/twg_guard.sv
//
// Contract
// - Key write AAH starts a three machine-cycle wait for 55H.
// - Window opens only if 55H follows AAH within three machine cycles.
// - Open window lasts three machine cycles, then closes by itself.
// - Protected writes take effect only while window open; otherwise discarded.
// - Reads of protected registers always return contents.
// - Several writes inside one window all succeed; later ones fail.
// - Protected set: A3H, 9FH, A4H, D8H, ABH.
// - Key register at C7H, eight bits, resets to all ones.
//
`include "twg_defines.svh"

module twg_guard
  import twg_pkg::*;
#(
  parameter int CLKS_PER_MC = `TWG_CLKS_PER_MC
) (
  input  wire logic        clk,           // 125 MHz system clock
  input  wire logic        rst_b,         // Synchronous reset, active low
  input  twg_sfr_req_t     sfr_req,       // Core SFR access, strobes one cycle
  output logic [7:0]       sfr_rdata_q,   // Read data, one cycle after rd
  output logic             sfr_hit_q,     // Last read hit a guarded address
  output twg_prot_bank_t   prot_regs_q,   // Protected register contents
  output logic             key_armed_q,   // Waiting for second key
  output logic             window_open_q  // Protected writes allowed
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (CLKS_PER_MC < 1 || CLKS_PER_MC > 255) begin : g_bad_mc
    $error("twg_guard: CLKS_PER_MC out of range");
  end

  localparam logic [7:0] MC_LAST = 8'(CLKS_PER_MC - 1);
  localparam logic [7:0] PROT_ADDR [`TWG_NUM_PROT] = '{
    `TWG_ADDR_PWR_MON, `TWG_ADDR_CHIP_CTL, `TWG_ADDR_PROG_TRIG,
    `TWG_ADDR_WDOG_CTL0, `TWG_ADDR_WDOG_CTL1};

  // ------------------------------------------------------------
  // Machine-cycle tick
  // ------------------------------------------------------------
  logic [7:0] mc_div_q;
  logic       mc_tick;

  // Divider free-runs, so a write may land anywhere inside a machine cycle
  assign mc_tick = (mc_div_q == MC_LAST);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mc_div_q <= 8'h00;
    end else if (mc_tick) begin
      mc_div_q <= 8'h00;
    end else begin
      mc_div_q <= mc_div_q + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Key register and sequence decode
  // ------------------------------------------------------------
  logic [7:0] key_q;
  logic       key_wr;
  logic       key_first;
  logic       key_second;
  logic       key_active;
  logic       win_active;
  twg_state_t state;

  assign key_wr     = sfr_req.wr && (sfr_req.addr == `TWG_ADDR_KEY);
  assign key_first  = key_wr && (sfr_req.wdata == `TWG_KEY_FIRST);
  assign key_second = key_wr && (sfr_req.wdata == `TWG_KEY_SECOND) && key_active;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      key_q <= `TWG_KEY_RESET;
    end else if (key_wr) begin
      key_q <= sfr_req.wdata;
    end
  end

  // Any other key write abandons a pending sequence
  twg_mc_count #(
    .WIDTH (3),
    .LOAD  (3'(`TWG_KEY_WAIT_MC))
  ) u_key_wait (
    .clk      (clk),
    .rst_b    (rst_b),
    .load     (key_first),
    .clear    (key_wr && !key_first),
    .mc_tick  (mc_tick),
    .active_q (key_active)
  );

  // Reloading on a fresh sequence restarts the full three cycles
  twg_mc_count #(
    .WIDTH (3),
    .LOAD  (3'(`TWG_WINDOW_MC))
  ) u_window (
    .clk      (clk),
    .rst_b    (rst_b),
    .load     (key_second),
    .clear    (1'b0),
    .mc_tick  (mc_tick),
    .active_q (win_active)
  );

  always_comb begin
    if (win_active) begin
      state = TWG_OPEN;
    end else if (key_active) begin
      state = TWG_ARMED;
    end else begin
      state = TWG_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      key_armed_q   <= 1'b0;
      window_open_q <= 1'b0;
    end else begin
      case (state)
        TWG_OPEN: begin
          key_armed_q   <= 1'b0;
          window_open_q <= 1'b1;
        end
        TWG_ARMED: begin
          key_armed_q   <= 1'b1;
          window_open_q <= 1'b0;
        end
        default: begin
          key_armed_q   <= 1'b0;
          window_open_q <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Protected registers
  // ------------------------------------------------------------
  logic [`TWG_NUM_PROT-1:0] prot_hit;

  for (genvar i = 0; i < `TWG_NUM_PROT; i++) begin : g_prot
    assign prot_hit[i] = (sfr_req.addr == PROT_ADDR[i]);

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        prot_regs_q[i] <= `TWG_PROT_RESET;
      end else if (sfr_req.wr && prot_hit[i] && win_active) begin
        prot_regs_q[i] <= sfr_req.wdata;
      end
    end

    property p_prot_take;
      @(posedge clk) disable iff (!rst_b)
      (sfr_req.wr && prot_hit[i] && win_active) |=> (prot_regs_q[i] == $past(sfr_req.wdata));
    endproperty
    a_prot_take: assert property (p_prot_take) else $error("window write lost");

    property p_prot_block;
      @(posedge clk) disable iff (!rst_b)
      (sfr_req.wr && prot_hit[i] && !win_active) |=> $stable(prot_regs_q[i]);
    endproperty
    a_prot_block: assert property (p_prot_block) else $error("closed window write took");
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [7:0] rd_mux;

  // Key register is write-only and reads as zero
  always_comb begin
    rd_mux = `TWG_READ_NONE;
    for (int j = 0; j < `TWG_NUM_PROT; j++) begin
      if (prot_hit[j]) begin
        rd_mux = prot_regs_q[j];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sfr_rdata_q <= `TWG_READ_NONE;
      sfr_hit_q   <= 1'b0;
    end else if (sfr_req.rd) begin
      sfr_rdata_q <= rd_mux;
      sfr_hit_q   <= |prot_hit;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [9:0] open_len_q;

  always_ff @(posedge clk) begin
    if (!rst_b || !win_active || key_second) begin
      open_len_q <= 10'h000;
    end else begin
      open_len_q <= open_len_q + 10'h001;
    end
  end

  property p_key_arm;
    @(posedge clk) disable iff (!rst_b)
    key_first |=> key_active;
  endproperty
  a_key_arm: assert property (p_key_arm) else $error("first key did not arm");

  property p_open;
    @(posedge clk) disable iff (!rst_b)
    (key_wr && sfr_req.wdata == `TWG_KEY_SECOND && key_active) |=> win_active ##1 window_open_q;
  endproperty
  a_open: assert property (p_open) else $error("second key did not open");

  property p_no_open;
    @(posedge clk) disable iff (!rst_b)
    (key_wr && sfr_req.wdata == `TWG_KEY_SECOND && !key_active && !win_active) |=> !win_active;
  endproperty
  a_no_open: assert property (p_no_open) else $error("late key opened window");

  property p_win_len;
    @(posedge clk) disable iff (!rst_b)
    win_active |-> (open_len_q < 10'(3 * CLKS_PER_MC));
  endproperty
  a_win_len: assert property (p_win_len) else $error("window open too long");

  property p_win_min;
    @(posedge clk) disable iff (!rst_b)
    ($fell(win_active)) |-> ($past(open_len_q) >= 10'(2 * CLKS_PER_MC));
  endproperty
  a_win_min: assert property (p_win_min) else $error("window closed too early");

  property p_read;
    @(posedge clk) disable iff (!rst_b)
    (sfr_req.rd && |prot_hit) |=> (sfr_rdata_q == $past(rd_mux)) && sfr_hit_q;
  endproperty
  a_read: assert property (p_read) else $error("protected read wrong");

  property p_reset;
    @(posedge clk) disable iff (1'b0)
    !rst_b |=> !win_active && !key_active && (key_q == `TWG_KEY_RESET);
  endproperty
  a_reset: assert property (p_reset) else $error("reset left key state");

endmodule : twg_guard

// ===== verification/twg_core_model.sv
`include "twg_defines.svh"

// ------------------------------------------------------------
// Core side model: SFR writes and reads
// ------------------------------------------------------------
module twg_core_model
  import twg_pkg::*;
(
  input  wire logic   clk,  // System clock
  output twg_sfr_req_t req   // Request to the guard
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a);
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
  endtask : sfr_read

  // Released bus flips, so a stale value never looks valid
  task automatic idle(input int n);
    repeat (n) @(posedge clk) req <= '{1'b0, 1'b0, ~req.addr, ~req.wdata};
  endtask : idle

  // Interrupts held off, so nothing stretches the key gap
  task automatic unlock(input int gap);
    sfr_write(`TWG_ADDR_KEY, `TWG_KEY_FIRST);
    idle(gap);
    sfr_write(`TWG_ADDR_KEY, `TWG_KEY_SECOND);
  endtask : unlock
endmodule : twg_core_model

// ===== verification/tb_top.sv
`include "twg_defines.svh"

module tb_top
  import twg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Stimulus, notes and checks
  // ------------------------------------------------------------
  localparam logic [7:0] ADDRS [5] = '{`TWG_ADDR_PWR_MON, `TWG_ADDR_CHIP_CTL,
    `TWG_ADDR_PROG_TRIG, `TWG_ADDR_WDOG_CTL0, `TWG_ADDR_WDOG_CTL1};
  logic         clk     = 1'b0;
  logic         rst_b   = 1'b0;
  logic         rd_pend = 1'b0;
  twg_sfr_req_t req;
  logic [7:0]   rdata;
  logic         hit;
  logic         armed;
  logic         wopen;
  logic [7:0]   d;
  twg_prot_bank_t bank;
  logic [7:0]   exp_regs [5];
  logic [8:0]   notes [$];
  int           errors  = 0;
  int           checks  = 0;
  int           seed    = 76812;

  always #4 clk = ~clk;

  twg_guard #(.CLKS_PER_MC(2)) twg_guard_inst (.clk(clk), .rst_b(rst_b), .sfr_req(req),
    .sfr_rdata_q(rdata), .sfr_hit_q(hit), .prot_regs_q(bank), .key_armed_q(armed),
    .window_open_q(wopen));
  twg_core_model twg_core_model_inst (.clk(clk), .req(req));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp_read(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_read

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_read({8'h00, got}, {8'h00, exp});
  endtask : cmp_flag

  // Register contents straight from the bank outputs
  task automatic cmp_bank();
    for (int i = 0; i < 5; i++) cmp_read({1'b1, bank[i]}, {1'b1, exp_regs[i]});
  endtask : cmp_bank

  task automatic rd_chk(input logic [7:0] a, input logic [8:0] e);
    notes.push_back(e);
    twg_core_model_inst.sfr_read(a);
  endtask : rd_chk

  task automatic rd_all();
    for (int i = 0; i < 5; i++) rd_chk(ADDRS[i], {1'b1, exp_regs[i]});
  endtask : rd_all

  task automatic wr_prot(input int i, input logic ok);
    d = 8'($random(seed));
    if (ok) exp_regs[i] = d;
    twg_core_model_inst.sfr_write(ADDRS[i], d);
  endtask : wr_prot

  // Answer is the registered value from the previous edge
  always @(posedge clk) begin
    if (rd_pend) cmp_read({hit, rdata}, notes.pop_front());
    rd_pend = req.rd & rst_b;
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    foreach (exp_regs[i]) exp_regs[i] = `TWG_PROT_RESET;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd_all();
    #1 cmp_bank();
    rd_chk(`TWG_ADDR_KEY, 9'h000);
    rd_chk({1'b0, 7'($random(seed))}, 9'h000);
    for (int i = 0; i < 5; i++) wr_prot(i, 1'b0);
    rd_all();
    #1 cmp_bank();
    twg_core_model_inst.unlock(0);
    wr_prot(1, 1'b1);
    wr_prot(3, 1'b1);
    twg_core_model_inst.idle(1);
    #1 cmp_flag(wopen, 1'b1);
    twg_core_model_inst.idle(7);
    #1 cmp_flag(wopen, 1'b0);
    wr_prot(0, 1'b0);
    rd_all();
    #1 cmp_bank();
    twg_core_model_inst.sfr_write(`TWG_ADDR_KEY, `TWG_KEY_FIRST);
    twg_core_model_inst.idle(2);
    #1 cmp_flag(armed, 1'b1);
    twg_core_model_inst.idle(7);
    #1 cmp_flag(armed, 1'b0);
    twg_core_model_inst.sfr_write(`TWG_ADDR_KEY, `TWG_KEY_SECOND);
    wr_prot(2, 1'b0);
    // Stray key value abandons the pending sequence
    d = 8'($random(seed)) & 8'hF0;
    twg_core_model_inst.sfr_write(`TWG_ADDR_KEY, `TWG_KEY_FIRST);
    twg_core_model_inst.sfr_write(`TWG_ADDR_KEY, d);
    twg_core_model_inst.sfr_write(`TWG_ADDR_KEY, `TWG_KEY_SECOND);
    wr_prot(0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      twg_core_model_inst.unlock(1);
      wr_prot(i, 1'b1);
    end
    rd_all();
    #1 cmp_bank();
    twg_core_model_inst.unlock(0);
    @(posedge clk) rst_b <= 1'b0;
    twg_core_model_inst.idle(2);
    rst_b <= 1'b1;
    foreach (exp_regs[i]) exp_regs[i] = `TWG_PROT_RESET;
    wr_prot(4, 1'b0);
    rd_all();
    #1 cmp_bank();
    twg_core_model_inst.idle(3);
    report_and_stop();
  end
endmodule : tb_top
